// file: pkg/rpf_defs.svh
// Purpose: Shared constants of the radio packet framer.
// Assumes: Included by bare name wherever a constant is needed.
// Notes:   Definitions only.
`ifndef RPF_DEFS_SVH
`define RPF_DEFS_SVH

// ============================================================
// Framing constants
`define RPF_SOF_NONE        8'h00
`define RPF_PREAMBLE_PAT    8'hAA
`define RPF_ID_BYTES        2
`define RPF_MEM_DEPTH       256

// ============================================================
// Check sequence defaults
`define RPF_CRC_POLY        8'h07
`define RPF_CRC_INIT        8'h00

`endif

// file: pkg/rpf_pkg.sv
// Purpose: Types of the radio packet framer.
// Assumes: Nothing.
// Notes:   Constants live in rpf_defs.svh.
package rpf_pkg;

  // ============================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_HUNT, ST_RLEN, ST_RBODY, ST_RCRC, ST_WAIT, ST_DELIVER,
    ST_LOAD, ST_PRE, ST_SOF, ST_TID, ST_TLEN, ST_TPAY, ST_TCRC, ST_DRAIN, ST_HOLD
  } rpf_state_t;

  // ============================================================
  // Radio mode shown to the host
  typedef enum logic [1:0] {
    MODE_STANDBY, MODE_IDLE, MODE_RX, MODE_TX
  } rpf_mode_t;

endpackage

// file: hw/rpf_crc8.sv
// Purpose: Running eight-bit check sequence over whole bytes.
// Assumes: Bytes are fed most significant bit first.
// Notes:   A clear and a byte in one cycle folds the byte into the start value.
`timescale 1ns/1ps
`include "rpf_defs.svh"

module rpf_crc8 #(
  parameter logic [7:0] POLY = `RPF_CRC_POLY,
  parameter logic [7:0] INIT = `RPF_CRC_INIT
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       clr_i,
  input  wire logic       en_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] crc_o
);

  logic [7:0] crc_q;
  logic [7:0] crc_d;

  // ============================================================
  // Next value
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ POLY) : (r << 1);
    end
    return r;
  endfunction

  always_comb begin
    crc_d = clr_i ? INIT : crc_q;
    if (en_i) begin
      crc_d = crc_step(crc_d, data_i);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      crc_q <= INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule

// file: hw/rpf_framer.sv
// Purpose: Packet framer with identifier match, length byte and check byte.
// Assumes: Radio bits arrive and leave one per strobe, most significant bit first.
// Notes:   Host data moves a byte per valid and ready handshake.
`timescale 1ns/1ps
`include "rpf_defs.svh"

module rpf_framer #(
  parameter int         ID_BYTES = `RPF_ID_BYTES,
  parameter int         DEPTH    = `RPF_MEM_DEPTH,
  parameter logic [7:0] PRE_PAT  = `RPF_PREAMBLE_PAT,
  parameter logic [7:0] POLY     = `RPF_CRC_POLY,
  parameter logic [7:0] INIT     = `RPF_CRC_INIT
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    cfg_id_en_i,
  input  wire logic                    cfg_len_en_i,
  input  wire logic                    cfg_crc_en_i,
  input  wire logic                    cfg_buf_tx_i,
  input  wire logic                    cfg_prior_idle_i,
  input  wire logic [ID_BYTES*8-1:0]   cfg_chip_id_i,
  input  wire logic [7:0]              cfg_sof_i,
  input  wire logic [7:0]              cfg_preamble_len_i,
  input  wire logic                    rx_cmd_i,
  input  wire logic                    tx_cmd_i,
  input  wire logic                    stop_cmd_i,
  input  wire logic                    rx_bit_i,
  input  wire logic                    rx_bit_stb_i,
  input  wire logic                    tx_bit_stb_i,
  output logic                         tx_bit_o,
  output logic                         tx_bit_valid_o,
  output logic                         tx_pwr_o,
  output logic                         data_if_ready_o,
  output logic                         pkt_irq_o,
  output rpf_pkg::rpf_mode_t           radio_mode_o,
  input  wire logic [7:0]              hd_in_data_i,
  input  wire logic                    hd_in_valid_i,
  output logic                         hd_in_ready_o,
  output logic [7:0]                   hd_out_data_o,
  output logic                         hd_out_valid_o,
  input  wire logic                    hd_out_ready_i
);

  localparam int ID_W = ID_BYTES * 8;
  localparam int AW   = $clog2(DEPTH);
  localparam logic [8:0] MAX_LEN = 9'(DEPTH - 1);

  // ============================================================
  // Parameter checks
  if (ID_BYTES < 1 || ID_BYTES > 4 || DEPTH < 2 || DEPTH > 256) begin : g_chk
    $error("rpf_framer: ID_BYTES must be 1..4 and DEPTH 2..256");
  end

  // ============================================================
  // State
  rpf_pkg::rpf_state_t st_q, st_d;
  logic [8:0]      idx_q, idx_d;
  logic [7:0]      len_q, len_d;
  logic [2:0]      bit_q, bit_d;
  logic [ID_W-1:0] id_sr_q, id_sr_d;
  logic [5:0]      fill_q, fill_d;
  logic [7:0]      rx_sr_q, rx_sr_d;
  logic [7:0]      tx_sr_q, tx_sr_d;
  logic            full_q, full_d;
  logic            prev_idle_q, prev_idle_d;
  logic            buf_q, buf_d;
  logic            irq_q, irq_d;
  logic            ov_q, ov_d;
  logic [7:0]      od_q, od_d;
  logic [7:0]      mem [DEPTH];
  logic            we;
  logic [AW-1:0]   wa;
  logic [7:0]      wd;
  logic [7:0]      rd;
  logic            crc_clr, crc_en;
  logic [7:0]      crc_din, crc_w;
  logic            chk_on, rx_ok, rx_bad, match, src_ok, pull;
  logic [7:0]      rx_byte, src;
  logic [ID_W-1:0] sr_n;
  logic            byte_stb;
  rpf_pkg::rpf_state_t start_st, after_pre, tail_st;

  function automatic logic [7:0] id_byte(input logic [ID_W-1:0] id, input logic [8:0] i);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < ID_BYTES; k++) begin
      if (i == 9'(k)) begin
        b = id[ID_W-1-8*k -: 8];
      end
    end
    return b;
  endfunction

  rpf_crc8 #(.POLY(POLY), .INIT(INIT)) u_crc (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clr_i     (crc_clr),
    .en_i      (crc_en),
    .data_i    (crc_din),
    .crc_o     (crc_w)
  );

  // ============================================================
  // Sequencer
  always_comb begin
    st_d = st_q; idx_d = idx_q; len_d = len_q; bit_d = bit_q;
    id_sr_d = id_sr_q; fill_d = fill_q; rx_sr_d = rx_sr_q; tx_sr_d = tx_sr_q;
    full_d = full_q; prev_idle_d = prev_idle_q; buf_d = buf_q; irq_d = irq_q;
    ov_d = ov_q; od_d = od_q;
    we = 1'b0; wa = idx_q[AW-1:0]; wd = 8'h00;
    crc_clr = 1'b0; crc_en = 1'b0; crc_din = 8'h00;
    rx_ok = 1'b0; rx_bad = 1'b0; pull = 1'b0;
    chk_on = cfg_id_en_i & cfg_len_en_i & cfg_crc_en_i;
    rx_byte = {rx_sr_q[6:0], rx_bit_i};
    byte_stb = rx_bit_stb_i && (bit_q == 3'h7);
    sr_n = {id_sr_q[ID_W-2:0], rx_bit_i};
    match = !cfg_id_en_i || (rx_bit_stb_i && (fill_q >= 6'(ID_W - 1)) && sr_n == cfg_chip_id_i);
    after_pre = (cfg_sof_i != `RPF_SOF_NONE) ? rpf_pkg::ST_SOF : rpf_pkg::ST_TID;
    start_st = (cfg_preamble_len_i != 8'h00) ? rpf_pkg::ST_PRE : after_pre;
    tail_st = chk_on ? rpf_pkg::ST_TCRC : rpf_pkg::ST_DRAIN;
    src = buf_q ? rd : hd_in_data_i;
    src_ok = buf_q || hd_in_valid_i;
    if (full_q && tx_bit_stb_i) begin
      tx_sr_d = {tx_sr_q[6:0], 1'b0};
      bit_d = bit_q + 3'h1;
      full_d = (bit_q != 3'h7);
    end
    if (st_q == rpf_pkg::ST_IDLE || st_q == rpf_pkg::ST_WAIT || st_q == rpf_pkg::ST_HOLD) begin
      if (rx_cmd_i) begin
        st_d = rpf_pkg::ST_HUNT;
        fill_d = 6'h00;
        prev_idle_d = cfg_prior_idle_i;
      end else if (tx_cmd_i) begin
        idx_d = 9'h000;
        bit_d = 3'h0;
        buf_d = cfg_buf_tx_i;
        crc_clr = 1'b1;
        st_d = cfg_buf_tx_i ? rpf_pkg::ST_LOAD : start_st;
      end
    end
    if (st_q == rpf_pkg::ST_RLEN || st_q == rpf_pkg::ST_RBODY || st_q == rpf_pkg::ST_RCRC) begin
      if (rx_bit_stb_i) begin
        rx_sr_d = rx_byte;
        bit_d = bit_q + 3'h1;
      end
    end
    case (st_q)
      rpf_pkg::ST_HUNT: begin
        if (rx_bit_stb_i) begin
          id_sr_d = sr_n;
          fill_d = (fill_q == 6'h3F) ? fill_q : fill_q + 6'h01;
        end
        if (match) begin
          st_d = rpf_pkg::ST_RLEN;
          crc_clr = 1'b1;
          bit_d = 3'h0;
        end
      end
      rpf_pkg::ST_RLEN: begin
        if (byte_stb) begin
          len_d = rx_byte;
          we = 1'b1;
          wa = '0;
          wd = rx_byte;
          crc_en = 1'b1;
          crc_din = rx_byte;
          idx_d = 9'h001;
          if ({1'b0, rx_byte} > MAX_LEN) begin
            rx_bad = 1'b1;
          end else if (rx_byte == 8'h00) begin
            st_d = chk_on ? rpf_pkg::ST_RCRC : rpf_pkg::ST_RLEN;
            rx_ok = !chk_on;
          end else begin
            st_d = rpf_pkg::ST_RBODY;
          end
        end
      end
      rpf_pkg::ST_RBODY: begin
        if (byte_stb) begin
          we = 1'b1;
          wd = rx_byte;
          crc_en = 1'b1;
          crc_din = rx_byte;
          idx_d = idx_q + 9'h001;
          if (idx_q == {1'b0, len_q}) begin
            st_d = rpf_pkg::ST_RCRC;
            rx_ok = !chk_on;
          end
        end
      end
      rpf_pkg::ST_RCRC: begin
        if (byte_stb) begin
          rx_ok = (rx_byte == crc_w);
          rx_bad = (rx_byte != crc_w);
        end
      end
      rpf_pkg::ST_DELIVER: begin
        if (!ov_q || hd_out_ready_i) begin
          if (idx_q <= {1'b0, len_q}) begin
            ov_d = 1'b1;
            od_d = rd;
            idx_d = idx_q + 9'h001;
          end else begin
            ov_d = 1'b0;
            irq_d = 1'b0;
            st_d = rpf_pkg::ST_IDLE;
          end
        end
      end
      rpf_pkg::ST_LOAD: begin
        if (hd_in_valid_i) begin
          we = 1'b1;
          wd = hd_in_data_i;
          idx_d = idx_q + 9'h001;
          if (idx_q == 9'h000) begin
            len_d = hd_in_data_i;
          end
          if (idx_q == 9'h000 && {1'b0, hd_in_data_i} > MAX_LEN) begin
            st_d = rpf_pkg::ST_IDLE;
          end else if ((idx_q == 9'h000 && hd_in_data_i == 8'h00) ||
                       (idx_q != 9'h000 && idx_q == {1'b0, len_q})) begin
            st_d = start_st;
            idx_d = 9'h000;
          end
        end
      end
      rpf_pkg::ST_PRE: begin
        if (!full_q) begin
          tx_sr_d = PRE_PAT; full_d = 1'b1; bit_d = 3'h0;
          idx_d = idx_q + 9'h001;
          if (idx_q + 9'h001 == {1'b0, cfg_preamble_len_i}) begin
            st_d = after_pre;
            idx_d = 9'h000;
          end
        end
      end
      rpf_pkg::ST_SOF: begin
        if (!full_q) begin
          tx_sr_d = cfg_sof_i; full_d = 1'b1; bit_d = 3'h0;
          st_d = rpf_pkg::ST_TID;
        end
      end
      rpf_pkg::ST_TID: begin
        if (!full_q) begin
          tx_sr_d = id_byte(cfg_chip_id_i, idx_q); full_d = 1'b1; bit_d = 3'h0;
          crc_en = 1'b1;
          crc_din = id_byte(cfg_chip_id_i, idx_q);
          idx_d = idx_q + 9'h001;
          if (idx_q == 9'(ID_BYTES - 1)) begin
            st_d = rpf_pkg::ST_TLEN;
            idx_d = 9'h000;
          end
        end
      end
      rpf_pkg::ST_TLEN, rpf_pkg::ST_TPAY: begin
        if (!full_q && src_ok) begin
          tx_sr_d = src; full_d = 1'b1; bit_d = 3'h0;
          pull = !buf_q;
          crc_en = 1'b1;
          crc_din = src;
          idx_d = idx_q + 9'h001;
          if (st_q == rpf_pkg::ST_TLEN) begin
            len_d = src;
            st_d = (src == 8'h00) ? tail_st : rpf_pkg::ST_TPAY;
          end else if (idx_q == {1'b0, len_q}) begin
            st_d = tail_st;
          end
        end
      end
      rpf_pkg::ST_TCRC: begin
        if (!full_q) begin
          tx_sr_d = crc_w; full_d = 1'b1; bit_d = 3'h0;
          st_d = rpf_pkg::ST_DRAIN;
        end
      end
      rpf_pkg::ST_DRAIN: begin
        if (!full_q) begin
          st_d = rpf_pkg::ST_HOLD;
        end
      end
      default: begin
      end
    endcase
    if (rx_ok) begin
      st_d = rpf_pkg::ST_DELIVER;
      irq_d = 1'b1;
      idx_d = 9'h000;
      ov_d = 1'b0;
    end
    if (rx_bad) begin
      st_d = prev_idle_q ? rpf_pkg::ST_HUNT : rpf_pkg::ST_WAIT;
      fill_d = 6'h00;
    end
    if (stop_cmd_i) begin
      st_d = rpf_pkg::ST_IDLE;
      full_d = 1'b0;
      ov_d = 1'b0;
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_q <= rpf_pkg::ST_IDLE; idx_q <= 9'h000; len_q <= 8'h00; bit_q <= 3'h0;
      id_sr_q <= '0; fill_q <= 6'h00; rx_sr_q <= 8'h00; tx_sr_q <= 8'h00;
      full_q <= 1'b0; prev_idle_q <= 1'b0; buf_q <= 1'b0; irq_q <= 1'b0;
      ov_q <= 1'b0; od_q <= 8'h00;
    end else begin
      st_q <= st_d; idx_q <= idx_d; len_q <= len_d; bit_q <= bit_d;
      id_sr_q <= id_sr_d; fill_q <= fill_d; rx_sr_q <= rx_sr_d; tx_sr_q <= tx_sr_d;
      full_q <= full_d; prev_idle_q <= prev_idle_d; buf_q <= buf_d; irq_q <= irq_d;
      ov_q <= ov_d; od_q <= od_d;
    end
  end

  // ============================================================
  // Packet memory
  always_ff @(posedge ref_clk_i) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end

  assign rd = mem[idx_q[AW-1:0]];

  // ============================================================
  // Outputs
  always_comb begin
    case (st_q)
      rpf_pkg::ST_HUNT, rpf_pkg::ST_RLEN, rpf_pkg::ST_RBODY, rpf_pkg::ST_RCRC,
      rpf_pkg::ST_WAIT: radio_mode_o = rpf_pkg::MODE_RX;
      rpf_pkg::ST_PRE, rpf_pkg::ST_SOF, rpf_pkg::ST_TID, rpf_pkg::ST_TLEN,
      rpf_pkg::ST_TPAY, rpf_pkg::ST_TCRC, rpf_pkg::ST_DRAIN,
      rpf_pkg::ST_HOLD: radio_mode_o = rpf_pkg::MODE_TX;
      default: radio_mode_o = prev_idle_q ? rpf_pkg::MODE_IDLE : rpf_pkg::MODE_STANDBY;
    endcase
  end

  assign tx_pwr_o = (st_q >= rpf_pkg::ST_PRE) && (st_q <= rpf_pkg::ST_DRAIN);
  assign tx_bit_o = tx_sr_q[7];
  assign tx_bit_valid_o = full_q;
  assign data_if_ready_o = (st_q >= rpf_pkg::ST_RLEN && st_q <= rpf_pkg::ST_RCRC) ||
                           st_q == rpf_pkg::ST_DELIVER || st_q == rpf_pkg::ST_LOAD;
  assign pkt_irq_o = irq_q;
  assign hd_in_ready_o = (st_q == rpf_pkg::ST_LOAD) || pull;
  assign hd_out_data_o = od_q;
  assign hd_out_valid_o = ov_q;

  // ============================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  ready_on_match_a: assert property (st_q == rpf_pkg::ST_HUNT && match && !stop_cmd_i |=> data_if_ready_o) else $error("not ready after match");
  crc_start_rx_a: assert property (st_q == rpf_pkg::ST_HUNT && match && !stop_cmd_i |=> crc_w == INIT) else $error("rx check not restarted");
  len_capture_a: assert property (st_q == rpf_pkg::ST_RLEN && byte_stb && !stop_cmd_i |=> len_q == $past(rx_byte)) else $error("length byte lost");
  bad_crc_wait_a: assert property (st_q == rpf_pkg::ST_RCRC && byte_stb && rx_byte != crc_w && !prev_idle_q && !stop_cmd_i |=> st_q == rpf_pkg::ST_WAIT) else $error("bad packet not held");
  good_irq_a: assert property (st_q == rpf_pkg::ST_RCRC && byte_stb && rx_byte == crc_w && !stop_cmd_i |=> pkt_irq_o && st_q == rpf_pkg::ST_DELIVER) else $error("good packet no interrupt");
  deliver_excl_a: assert property (st_q == rpf_pkg::ST_DELIVER && hd_out_valid_o |-> idx_q <= {1'b0, len_q} + 9'h001) else $error("delivered past length");
  load_ready_a: assert property (st_q == rpf_pkg::ST_LOAD |-> hd_in_ready_o && !tx_pwr_o) else $error("load not ready");
  tx_power_a: assert property (st_q == rpf_pkg::ST_IDLE && tx_cmd_i && !rx_cmd_i && !cfg_buf_tx_i && !stop_cmd_i |=> tx_pwr_o) else $error("transmitter not powered");
  sof_skip_a: assert property (st_q == rpf_pkg::ST_SOF && !full_q && !stop_cmd_i |=> tx_sr_q == $past(cfg_sof_i) && $past(cfg_sof_i) != 8'h00) else $error("zero start byte sent");
  crc_last_a: assert property (st_q == rpf_pkg::ST_TCRC && !full_q && !stop_cmd_i |=> tx_sr_q == $past(crc_w) && st_q == rpf_pkg::ST_DRAIN) else $error("check byte wrong");
  hold_a: assert property (st_q == rpf_pkg::ST_HOLD && !rx_cmd_i && !tx_cmd_i && !stop_cmd_i |=> st_q == rpf_pkg::ST_HOLD) else $error("hold left without command");

endmodule

// file: dv/rpf_host_model.sv
// Purpose: Host controller model on the framer's byte port.
// Assumes: One clock; signals change 1 ns after the rising edge.
// Notes:   Feeds queued bytes in and collects delivered bytes, with an optional stall.
`timescale 1ns/1ps

module rpf_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       slow_i,
  input  wire logic       hd_in_ready_i,
  input  wire logic [7:0] hd_out_data_i,
  input  wire logic       hd_out_valid_i,
  output logic      [7:0] hd_in_data_o,
  output logic            hd_in_valid_o,
  output logic            hd_out_ready_o
);
  // ============================================================
  // Byte queues
  logic [7:0] q_in [$];
  logic [7:0] q_out [$];
  logic [7:0] last_q = 8'h00;
  logic       tog_q  = 1'b0;

  initial begin
    hd_in_data_o   = 8'hFF;
    hd_in_valid_o  = 1'b0;
    hd_out_ready_o = 1'b0;
  end

  // ============================================================
  // Handshakes
  always @(posedge ref_clk_i) begin
    if (hd_out_valid_i && hd_out_ready_o) begin
      q_out.push_back(hd_out_data_i);
    end
    if (hd_in_valid_o && hd_in_ready_i) begin
      last_q = q_in.pop_front();
    end
    #1;
    tog_q = ~tog_q;
    // A released data bus shows the inverse of the last byte.
    hd_in_valid_o  = !reset_i && (q_in.size() != 0);
    hd_in_data_o   = hd_in_valid_o ? q_in[0] : ~last_q;
    hd_out_ready_o = !reset_i && (!slow_i || tog_q);
  end
endmodule

// file: dv/testbench.sv
// Purpose: Self-checking bench of the packet framer.
// Assumes: Check sequence is polynomial 07h, start 00h, most significant bit first.
// Notes:   Reset checks, then table rows, then hand-written cases.
`timescale 1ns/1ps

module testbench;
  // ============================================================
  // Constants and signals
  localparam logic [15:0] ID   = 16'hC35A;
  localparam logic [7:0]  PRE  = 8'hAA;
  localparam logic [7:0]  POLY = 8'h07;
  typedef struct {bit tx; int len; bit alt; logic [7:0] sof; logic [7:0] pre;
    bit crc; bit prior; bit slow; logic irq; rpf_pkg::rpf_mode_t mode;} rpf_row_t;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic id_en = 1'b1, len_en = 1'b1, crc_en = 1'b1, buf_tx = 1'b0, prior = 1'b0;
  logic [7:0] sof = 8'h00, pre_len = 8'h00;
  logic rx_cmd = 1'b0, tx_cmd = 1'b0, stop_cmd = 1'b0, rx_bit = 1'b0, rx_stb = 1'b0;
  logic tx_stb = 1'b0, slow = 1'b0;
  logic tx_bit, tx_vld, tx_pwr, if_rdy, irq, in_rdy, in_vld, out_vld, out_rdy;
  logic [7:0] in_data, out_data, acc;
  rpf_pkg::rpf_mode_t mode;
  logic [7:0] txq [$];
  logic [7:0] expq [$];
  int nb = 0;
  int mismatches = 0;
  int n_tests = 0;
  rpf_row_t rows [9] = '{
    '{1, 3, 0, 8'h55, 8'h02, 1, 0, 0, 1'b0, rpf_pkg::MODE_TX},
    '{1, 0, 1, 8'h00, 8'h00, 1, 0, 1, 1'b0, rpf_pkg::MODE_TX},
    '{1, 4, 1, 8'h0A, 8'h01, 0, 0, 0, 1'b0, rpf_pkg::MODE_TX},
    '{1, 2, 0, 8'h00, 8'h03, 1, 0, 1, 1'b0, rpf_pkg::MODE_TX},
    '{0, 4, 0, 8'h00, 8'h00, 1, 1, 1, 1'b1, rpf_pkg::MODE_IDLE},
    '{0, 0, 0, 8'h00, 8'h00, 1, 0, 0, 1'b1, rpf_pkg::MODE_STANDBY},
    '{0, 3, 0, 8'h00, 8'h00, 0, 0, 1, 1'b1, rpf_pkg::MODE_STANDBY},
    '{0, 2, 1, 8'h00, 8'h00, 1, 0, 0, 1'b0, rpf_pkg::MODE_RX},
    '{0, 2, 1, 8'h00, 8'h00, 1, 1, 1, 1'b1, rpf_pkg::MODE_IDLE}};

  always #5 ref_clk_i = ~ref_clk_i;

  rpf_framer #(.ID_BYTES(2), .DEPTH(256), .PRE_PAT(PRE), .POLY(POLY), .INIT(8'h00)) uut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_id_en_i(id_en), .cfg_len_en_i(len_en),
    .cfg_crc_en_i(crc_en), .cfg_buf_tx_i(buf_tx), .cfg_prior_idle_i(prior),
    .cfg_chip_id_i(ID), .cfg_sof_i(sof), .cfg_preamble_len_i(pre_len), .rx_cmd_i(rx_cmd),
    .tx_cmd_i(tx_cmd), .stop_cmd_i(stop_cmd), .rx_bit_i(rx_bit), .rx_bit_stb_i(rx_stb),
    .tx_bit_stb_i(tx_stb), .tx_bit_o(tx_bit), .tx_bit_valid_o(tx_vld), .tx_pwr_o(tx_pwr),
    .data_if_ready_o(if_rdy), .pkt_irq_o(irq), .radio_mode_o(mode),
    .hd_in_data_i(in_data), .hd_in_valid_i(in_vld), .hd_in_ready_o(in_rdy),
    .hd_out_data_o(out_data), .hd_out_valid_o(out_vld), .hd_out_ready_i(out_rdy));

  rpf_host_model host (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .slow_i(slow), .hd_in_ready_i(in_rdy),
    .hd_out_data_i(out_data), .hd_out_valid_i(out_vld), .hd_in_data_o(in_data),
    .hd_in_valid_o(in_vld), .hd_out_ready_o(out_rdy));

  // ============================================================
  // Radio strobe and transmit bit collector
  always @(posedge ref_clk_i) begin
    #1 tx_stb <= reset_i ? 1'b0 : (slow ? ~tx_stb : 1'b1);
  end
  always @(posedge ref_clk_i) begin
    if (!reset_i && tx_stb && tx_vld) begin
      acc = {acc[6:0], tx_bit};
      nb++;
      if (nb == 8) begin
        txq.push_back(acc);
        nb = 0;
      end
    end
  end

  // ============================================================
  // Helpers
  task automatic fail_line(input logic [7:0] got, input logic [7:0] exp);
    mismatches++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) fail_line({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) fail_line(got, exp);
  endtask
  task automatic chk_mode(input rpf_pkg::rpf_mode_t got, input rpf_pkg::rpf_mode_t exp);
    n_tests++;
    if (got !== exp) fail_line({6'h00, got}, {6'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      tick(1);
      k++;
    end
  endtask
  function automatic logic [7:0] crc_upd(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
    return c;
  endfunction
  function automatic logic [7:0] pay(int r, int k);
    return 8'(8'h3C + 8'h11 * k) ^ 8'(r);
  endfunction
  task automatic rx_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_bit = b[i];
      rx_stb = 1'b1;
      tick(1);
    end
  endtask
  task automatic rx_pkt(input int r, input logic [15:0] id, input int len, input bit bad,
                        input logic rdy);
    logic [7:0] c;
    c = crc_upd(8'h00, len[7:0]);
    rx_byte(id[15:8]);
    chk1(if_rdy, 1'b0);
    rx_byte(id[7:0]);
    chk1(if_rdy, rdy);
    rx_byte(len[7:0]);
    for (int k = 0; k < len; k++) begin
      c = crc_upd(c, pay(r, k));
      rx_byte(pay(r, k));
    end
    if (crc_en) rx_byte(bad ? ~c : c);
    rx_stb = 1'b0;
    rx_bit = ~rx_bit;
  endtask

  // ============================================================
  // Row runner
  task automatic run_row(input int r, input rpf_row_t w);
    logic [7:0] c;
    int n;
    crc_en = w.crc;
    prior = w.prior;
    slow = w.slow;
    sof = w.sof;
    pre_len = w.pre;
    buf_tx = w.alt;
    host.q_out.delete();
    if (w.tx) begin
      txq.delete();
      nb = 0;
      expq.delete();
      repeat (w.pre) expq.push_back(PRE);
      if (w.sof != 8'h00) expq.push_back(w.sof);
      n = expq.size();
      expq.push_back(ID[15:8]);
      expq.push_back(ID[7:0]);
      expq.push_back(w.len[7:0]);
      host.q_in.push_back(w.len[7:0]);
      for (int k = 0; k < w.len; k++) begin
        expq.push_back(pay(r, k));
        host.q_in.push_back(pay(r, k));
      end
      c = 8'h00;
      for (int i = n; i < expq.size(); i++) c = crc_upd(c, expq[i]);
      if (w.crc && id_en && len_en) expq.push_back(c);
      pulse(tx_cmd);
      if (w.alt) begin
        chk1(if_rdy, 1'b1);
        chk1(tx_pwr, 1'b0);
        wait_for(tx_pwr, 1'b1, 400);
        chk8(8'(host.q_in.size()), 8'h00);
      end else begin
        chk1(tx_pwr, 1'b1);
      end
      wait_for(tx_pwr, 1'b0, 3000);
      tick(2);
      chk8(8'(txq.size()), 8'(expq.size()));
      foreach (expq[i]) chk8(txq[i], expq[i]);
    end else begin
      pulse(rx_cmd);
      rx_pkt(r, ID, w.len, w.alt, 1'b1);
      if (w.alt) begin
        tick(3);
        chk1(irq, 1'b0);
        chk1(if_rdy, 1'b0);
        chk_mode(mode, rpf_pkg::MODE_RX);
        rx_pkt(r, ID, w.len, 1'b0, w.prior);
      end
      wait_for(irq, w.irq, 4);
      chk1(irq, w.irq);
      if (w.irq) begin
        wait_for(irq, 1'b0, 400);
        chk8(8'(host.q_out.size()), 8'(w.len + 1));
        chk8(host.q_out[0], w.len[7:0]);
        for (int k = 0; k < w.len; k++) chk8(host.q_out[k + 1], pay(r, k));
      end
    end
    chk_mode(mode, w.mode);
    pulse(stop_cmd);
    tick(1);
  endtask

  // ============================================================
  // Closing
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    chk1(tx_pwr, 1'b0);
    chk1(if_rdy, 1'b0);
    chk1(irq, 1'b0);
    chk1(out_vld, 1'b0);
    chk1(tx_vld, 1'b0);
    chk_mode(mode, rpf_pkg::MODE_STANDBY);
    foreach (rows[i]) run_row(i, rows[i]);
    len_en = 1'b0;
    run_row(0, rows[0]);
    len_en = 1'b1;
    crc_en = 1'b1;
    pulse(rx_cmd);
    rx_pkt(1, ~ID, 2, 1'b0, 1'b0);
    tick(3);
    chk1(irq, 1'b0);
    pulse(stop_cmd);
    wrap_up();
  end
endmodule
